// ==== axil_slave.sv ====
// AXI4-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
`include "limit_regs_defines.svh"
module axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  reg_bus_if.slave_side rb
);
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] waddr_reg, waddr_next, raddr_reg, raddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic ar_have_reg, ar_have_next;

  assign awready = !aw_have_reg && !bvalid_reg;
  assign wready = !w_have_reg && !bvalid_reg;
  assign arready = !ar_have_reg && !rvalid_reg;
  assign rb.wr_en = aw_have_reg && w_have_reg && !bvalid_reg;
  assign rb.wr_addr = waddr_reg;
  assign rb.wr_data = wdata_reg;
  assign rb.wr_strb = wstrb_reg;
  assign rb.rd_en = ar_have_reg;
  assign rb.rd_addr = raddr_reg;

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ar_have_next = ar_have_reg;
    raddr_next = raddr_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (awvalid && awready) begin
      aw_have_next = 1'b1;
      waddr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_have_next = 1'b1;
      wdata_next = wdata;
      wstrb_next = wstrb;
    end
    if (rb.wr_en) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = rb.wr_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (arvalid && arready) begin
      ar_have_next = 1'b1;
      raddr_next = araddr;
    end
    if (rb.rd_en) begin
      ar_have_next = 1'b0;
      rvalid_next = 1'b1;
      rdata_next = rb.rd_data;
      rresp_next = rb.rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      ar_have_reg <= 1'b0;
      raddr_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      ar_have_reg <= ar_have_next;
      raddr_reg <= raddr_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
endmodule : axil_slave
`default_nettype wire

// ==== limit_regs_defines.svh ====
// Offsets, reset values, widths and response codes of the sequencer limit registers
`ifndef LIMIT_REGS_DEFINES_SVH
`define LIMIT_REGS_DEFINES_SVH

`define ADDR_W 8
`define OFS_T0 8'h00
`define OFS_T1 8'h04
`define OFS_SD 8'h08
`define OFS_C0 8'h0c
`define OFS_C1 8'h10
`define LIM_W 16
`define RST_T0 16'hffff
`define RST_LIM 16'h0000
`define UPPER_ZERO 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== limit_regs_pkg.sv ====
// Types shared by the limit register block
`default_nettype none
package limit_regs_pkg;
  typedef enum logic [2:0] {
    SEL_T0 = 3'h0,
    SEL_T1 = 3'h1,
    SEL_SD = 3'h2,
    SEL_C0 = 3'h3,
    SEL_C1 = 3'h4,
    SEL_NONE = 3'h7
  } reg_sel_t;
  typedef logic [15:0] limit_t;
endpackage : limit_regs_pkg
`default_nettype wire

// ==== reg_bus_if.sv ====
// Internal register access strobes between bus slave and register file
`timescale 1ns/1ps
`default_nettype none
interface reg_bus_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport slave_side (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                      input wr_err, rd_data, rd_err);
  modport regs_side (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                     output wr_err, rd_data, rd_err);
endinterface : reg_bus_if
`default_nettype wire

// ==== trigger_sequencer_limit_regs.sv ====
// Limit registers of the trigger sequencer with their wait, step and loop users
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "limit_regs_defines.svh"
module trigger_sequencer_limit_regs
  import limit_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wait_t0_start,
  output logic wait_t0_busy,
  output logic wait_t0_done,
  input wire logic wait_t1_start,
  output logic wait_t1_busy,
  output logic wait_t1_done,
  input wire logic step_start,
  output logic step_busy,
  output logic step_done,
  input wire logic [1:0] jump_eval,
  output logic [1:0] jump_done,
  output logic [1:0] jump_take
);
  reg_bus_if rb ();

  axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rb(rb.slave_side)
  );

  // Low address bits ignored: every register is one aligned word
  function automatic reg_sel_t decode(input logic [7:0] addr);
    case ({addr[7:2], 2'b00})
      `OFS_T0: decode = SEL_T0;
      `OFS_T1: decode = SEL_T1;
      `OFS_SD: decode = SEL_SD;
      `OFS_C0: decode = SEL_C0;
      `OFS_C1: decode = SEL_C1;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  reg_sel_t wr_sel, rd_sel;
  limit_t t0_reg, t0_next, t1_reg, t1_next, sd_reg, sd_next;
  limit_t c0_reg, c0_next, c1_reg, c1_next;
  limit_t wr_merged, rd_val;

  assign wr_sel = decode(rb.wr_addr);
  assign rd_sel = decode(rb.rd_addr);
  assign rb.wr_err = (wr_sel == SEL_NONE);
  assign rb.rd_err = (rd_sel == SEL_NONE);

  always_comb begin
    unique case (rd_sel)
      SEL_T0: rd_val = t0_reg;
      SEL_T1: rd_val = t1_reg;
      SEL_SD: rd_val = sd_reg;
      SEL_C0: rd_val = c0_reg;
      SEL_C1: rd_val = c1_reg;
      default: rd_val = `RST_LIM;
    endcase
  end

  // Upper half-word always reads as zero
  assign rb.rd_data = {`UPPER_ZERO, rd_val};

  always_comb begin
    unique case (wr_sel)
      SEL_T0: wr_merged = t0_reg;
      SEL_T1: wr_merged = t1_reg;
      SEL_SD: wr_merged = sd_reg;
      SEL_C0: wr_merged = c0_reg;
      SEL_C1: wr_merged = c1_reg;
      default: wr_merged = `RST_LIM;
    endcase
    // Only strobes 1:0 matter; upper lanes have no storage
    if (rb.wr_strb[0]) wr_merged[7:0] = rb.wr_data[7:0];
    if (rb.wr_strb[1]) wr_merged[15:8] = rb.wr_data[15:8];
  end

  always_comb begin
    t0_next = t0_reg;
    t1_next = t1_reg;
    sd_next = sd_reg;
    c0_next = c0_reg;
    c1_next = c1_reg;
    if (rb.wr_en) begin
      unique case (wr_sel)
        SEL_T0: t0_next = wr_merged;
        SEL_T1: t1_next = wr_merged;
        SEL_SD: sd_next = wr_merged;
        SEL_C0: c0_next = wr_merged;
        SEL_C1: c1_next = wr_merged;
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t0_reg <= `RST_T0;
      t1_reg <= `RST_LIM;
      sd_reg <= `RST_LIM;
      c0_reg <= `RST_LIM;
      c1_reg <= `RST_LIM;
    end else begin
      t0_reg <= t0_next;
      t1_reg <= t1_next;
      sd_reg <= sd_next;
      c0_reg <= c0_next;
      c1_reg <= c1_next;
    end
  end

  // Each limit only acts on its own kind of step
  wait_counter u_t0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(wait_t0_start),
    .load(t0_reg),
    .busy(wait_t0_busy),
    .done(wait_t0_done)
  );

  wait_counter u_t1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(wait_t1_start),
    .load(t1_reg),
    .busy(wait_t1_busy),
    .done(wait_t1_done)
  );

  // One base clock plus the programmed delay
  wait_counter u_step (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(step_start),
    .load(sd_reg),
    .busy(step_busy),
    .done(step_done)
  );

  // Loop counters: limit captured on the first pass of a loop
  limit_t loop_lim [0:1];
  limit_t cnt_reg [0:1];
  limit_t cnt_next [0:1];
  limit_t lat_reg [0:1];
  limit_t lat_next [0:1];
  logic [1:0] jdone_reg, jdone_next, jtake_reg, jtake_next;

  assign loop_lim[0] = c0_reg;
  assign loop_lim[1] = c1_reg;

  always_comb begin
    limit_t eff;
    eff = `RST_LIM;
    jdone_next = 2'b00;
    jtake_next = 2'b00;
    for (int i = 0; i < 2; i++) begin
      cnt_next[i] = cnt_reg[i];
      lat_next[i] = lat_reg[i];
      if (jump_eval[i]) begin
        // Sampling at loop entry keeps a mid-loop write from skewing the count
        eff = (cnt_reg[i] == 16'h0000) ? loop_lim[i] : lat_reg[i];
        lat_next[i] = eff;
        jdone_next[i] = 1'b1;
        if (cnt_reg[i] != eff) begin
          jtake_next[i] = 1'b1;
          cnt_next[i] = cnt_reg[i] + 16'h0001;
        end else begin
          cnt_next[i] = 16'h0000;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '{16'h0000, 16'h0000};
      lat_reg <= '{16'h0000, 16'h0000};
      jdone_reg <= 2'b00;
      jtake_reg <= 2'b00;
    end else begin
      cnt_reg <= cnt_next;
      lat_reg <= lat_next;
      jdone_reg <= jdone_next;
      jtake_reg <= jtake_next;
    end
  end

  assign jump_done = jdone_reg;
  assign jump_take = jtake_reg;

  upper_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half-word of read data not zero");

  t0_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wait_t0_start && t0_reg == 16'h0000) |=> wait_t0_done)
    else $error("timer zero wait with zero limit did not end next cycle");

  t1_one_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wait_t1_start && t1_reg == 16'h0001) ##1 !wait_t1_start
      |-> !wait_t1_done ##1 wait_t1_done)
    else $error("timer one wait with limit one not two cycles");

  step_base_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (step_start && sd_reg == 16'h0000) |=> step_done)
    else $error("step with zero delay not one cycle");

  step_six_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (step_start && sd_reg == 16'h0006) ##1 (!step_start && !step_done)[*6]
      |=> step_done)
    else $error("step with delay six not seven cycles");

  loop_exit_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (jump_eval[0] && cnt_reg[0] == 16'h0000 && c0_reg == 16'h0000)
      |=> jump_done[0] && !jump_take[0])
    else $error("counter zero loop with zero count did not fall through");

  reset_clear_a: assert property (
    @(posedge aclk)
    !aresetn |=> (t1_reg == 16'h0000 && sd_reg == 16'h0000 &&
                  c0_reg == 16'h0000 && c1_reg == 16'h0000 && t0_reg == `RST_T0))
    else $error("limit registers not at reset values after reset");

  c1_byte_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rb.wr_en && wr_sel == SEL_C1 && rb.wr_strb[1:0] == 2'b10)
      |=> c1_reg == {$past(rb.wr_data[15:8]), $past(c1_reg[7:0])})
    else $error("counter one limit byte write wrong");

  loop_take_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (jump_eval[1] && cnt_reg[1] == 16'h0000 && c1_reg != 16'h0000)
      |=> jump_take[1])
    else $error("counter one loop not taken on first pass");

  late_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (jump_eval[0] && cnt_reg[0] != 16'h0000) |=> lat_reg[0] == $past(lat_reg[0]))
    else $error("loop limit resampled in the middle of a loop");

  step_cover_c: cover property (
    @(posedge aclk) disable iff (!aresetn)
    step_start && sd_reg == 16'h0006 ##7 step_done);

  loop_cover_c: cover property (
    @(posedge aclk) disable iff (!aresetn)
    jump_take[1] ##[1:20] (jump_done[1] && !jump_take[1]));

  err_cover_c: cover property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule : trigger_sequencer_limit_regs
`default_nettype wire

// ==== trigger_sequencer_limit_regs_tb.sv ====
// Self-checking testbench for the sequencer limit registers and their users
`timescale 1ns/1ps
`default_nettype none
`include "limit_regs_defines.svh"
module trigger_sequencer_limit_regs_tb
  import limit_regs_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic [2:0] starts;
  wire [2:0] busys;
  wire [2:0] dones;
  logic [1:0] jump_eval;
  logic [1:0] jump_done;
  logic [1:0] jump_take;
  int miscompares = 0;
  int total_checks = 0;
  logic [15:0] lfsr_state = 16'hf72b;
  logic [7:0] offs [5] = '{`OFS_T0, `OFS_T1, `OFS_SD, `OFS_C0, `OFS_C1};
  logic [3:0] strobes [4] = '{4'h1, 4'h2, 4'hc, 4'h3};
  limit_t model_regs [5];
  limit_t loop_lat [2];
  int loop_cnt [2];

  always #2.5 aclk = ~aclk;

  trigger_sequencer_limit_regs u_trigger_sequencer_limit_regs (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wait_t0_start(starts[0]), .wait_t0_busy(busys[0]), .wait_t0_done(dones[0]),
    .wait_t1_start(starts[1]), .wait_t1_busy(busys[1]), .wait_t1_done(dones[1]),
    .step_start(starts[2]), .step_busy(busys[2]), .step_done(dones[2]),
    .jump_eval(jump_eval), .jump_done(jump_done), .jump_take(jump_take)
  );

  function automatic logic [15:0] rnd();
    lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
    return lfsr_state;
  endfunction : rnd

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // Handshakes are judged at the falling edge, where ready has settled
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] exp_resp);
    logic a_hs;
    logic w_hs;
    logic b_hs;
    b_hs = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hs) begin
      @(negedge aclk);
      a_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bready && bvalid;
      if (b_hs) check("bresp", {30'h0, bresp}, {30'h0, exp_resp});
      @(posedge aclk);
      if (a_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
    end
  endtask : bus_write

  task automatic read_check(input logic [7:0] a, input logic [31:0] exp,
                            input logic [1:0] exp_resp);
    logic a_hs;
    logic r_hs;
    r_hs = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs) begin
      @(negedge aclk);
      a_hs = arvalid && arready;
      r_hs = rready && rvalid;
      if (r_hs) begin
        check("rdata", rdata, exp);
        check("rresp", {30'h0, rresp}, {30'h0, exp_resp});
      end
      @(posedge aclk);
      if (a_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
    end
  endtask : read_check

  // Cycles counted from the cycle after the start cycle through the done cycle
  task automatic run_engine(input int which, output int cycles);
    @(posedge aclk);
    starts[which] <= 1'b1;
    @(posedge aclk);
    starts <= 3'h0;
    cycles = 1;
    @(negedge aclk);
    while (dones[which] !== 1'b1) begin
      check("busy", {31'h0, busys[which]}, 32'h1);
      cycles++;
      @(negedge aclk);
    end
    check("busy_at_done", {31'h0, busys[which]}, 32'h0);
  endtask : run_engine

  task automatic eval_loop(input int n);
    logic exp_take;
    @(posedge aclk);
    jump_eval[n] <= 1'b1;
    @(posedge aclk);
    jump_eval <= 2'h0;
    if (loop_cnt[n] == 0) loop_lat[n] = model_regs[3 + n];
    if (loop_cnt[n] != int'(loop_lat[n])) begin
      exp_take = 1'b1;
      loop_cnt[n]++;
    end else begin
      exp_take = 1'b0;
      loop_cnt[n] = 0;
    end
    @(negedge aclk);
    check("jump_done", {31'h0, jump_done[n]}, 32'h1);
    check("jump_take", {31'h0, jump_take[n]}, {31'h0, exp_take});
  endtask : eval_loop

  initial begin
    // Span generous for the bounded limits used below
    repeat (20000) @(posedge aclk);
    miscompares++;
    final_report();
  end

  initial begin
    logic [31:0] d;
    limit_t lim;
    int c;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, starts, jump_eval} = '0;
    loop_cnt = '{0, 0};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    model_regs[0] = `RST_T0;
    for (int i = 1; i < 5; i++) model_regs[i] = `RST_LIM;
    for (int i = 0; i < 5; i++) begin
      read_check(offs[i], {16'h0, model_regs[i]}, `RESP_OKAY);
    end
    for (int i = 0; i < 5; i++) begin
      d = {rnd(), rnd()};
      bus_write(offs[i], d, 4'hf, `RESP_OKAY);
      model_regs[i] = d[15:0];
      read_check(offs[i], {16'h0, model_regs[i]}, `RESP_OKAY);
    end
    // Byte lanes of the counter one limit, upper lanes must be dropped
    foreach (strobes[k]) begin
      d = {rnd(), rnd()};
      bus_write(`OFS_C1, d, strobes[k], `RESP_OKAY);
      if (strobes[k][0]) model_regs[4][7:0] = d[7:0];
      if (strobes[k][1]) model_regs[4][15:8] = d[15:8];
      read_check(`OFS_C1, {16'h0, model_regs[4]}, `RESP_OKAY);
    end
    bus_write(8'h14, 32'hffffffff, 4'hf, `RESP_SLVERR);
    read_check(8'h14, 32'h0, `RESP_SLVERR);
    // First pass uses edge limits, second pass random waits and a seven-clock step with delay six
    for (int w = 0; w < 6; w++) begin
      lim = (w < 3) ? ((w == 1) ? 16'h0001 : 16'h0000)
                    : ((w == 5) ? 16'h0006 : (rnd() & 16'h0007));
      bus_write(offs[w % 3], {16'h0, lim}, 4'hf, `RESP_OKAY);
      model_regs[w % 3] = lim;
      run_engine(w % 3, c);
      check("duration", c, 32'(lim) + 32'h1);
    end
    // A write during a running step must only affect the next step
    fork
      run_engine(2, c);
      begin
        repeat (2) @(posedge aclk);
        bus_write(`OFS_SD, 32'h1, 4'hf, `RESP_OKAY);
      end
    join
    check("duration_old", c, 32'h7);
    model_regs[2] = 16'h0001;
    run_engine(2, c);
    check("duration_new", c, 32'h2);
    for (int n = 0; n < 2; n++) begin
      // Counter zero opens with an empty loop, counter one with a taken one
      lim = (n == 0) ? 16'h0000 : ((rnd() & 16'h0003) | 16'h0001);
      bus_write(offs[3 + n], {16'h0, lim}, 4'hf, `RESP_OKAY);
      model_regs[3 + n] = lim;
      for (int e = 0; e < 8; e++) begin
        eval_loop(n);
        if (e == 0) begin
          lim = rnd() & 16'h0003;
          bus_write(offs[3 + n], {16'h0, lim}, 4'hf, `RESP_OKAY);
          model_regs[3 + n] = lim;
        end
      end
    end
    final_report();
  end
endmodule : trigger_sequencer_limit_regs_tb
`default_nettype wire

// ==== wait_counter.sv ====
// Down counter that pulses done one clock plus the loaded count after start
`timescale 1ns/1ps
`default_nettype none
module wait_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [15:0] load,
  output logic busy,
  output logic done
);
  logic [15:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;

  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start) begin
      // Load at start so a later write only affects the next run
      // Start cycle is the base clock, so a zero count finishes at once
      if (load == 16'h0000) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = load - 16'h0001;
        busy_next = 1'b1;
      end
    end else if (busy_reg) begin
      if (cnt_reg == 16'h0000) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
endmodule : wait_counter
`default_nettype wire
